// [hw/lamp_pkg.sv]
// Constants, register map and state carrier of the lamp switch serial port.
// Assumes a single 125 MHz clock domain; all pins are synchronised inside.
`default_nettype none
package lamp_pkg;
   // Clock and time figures
   localparam int unsigned CLK_PERIOD_NS   = 8;
   localparam int unsigned PWM_TICK_NS     = 32000;
   localparam int unsigned PWM_TICK_CYC    = PWM_TICK_NS / CLK_PERIOD_NS;
   localparam logic [15:0] PWM_DIV_LAST    = 16'(PWM_TICK_CYC - 1);
   localparam int unsigned WD_TIMEOUT_US   = 256000;
   localparam int unsigned WD_CYC_DEF      = WD_TIMEOUT_US * 1000
                                             / CLK_PERIOD_NS;
   localparam int unsigned CLK_FAIL_US     = 1000;
   localparam int unsigned CLK_FAIL_CYC_DEF = CLK_FAIL_US * 1000
                                             / CLK_PERIOD_NS;
   // Serial frame layout
   localparam logic [4:0]  FRAME_BITS      = 5'h10;
   localparam logic [4:0]  BITCNT_SAT      = 5'h1f;
   localparam int unsigned FA_MSB          = 15;
   localparam int unsigned FA_LSB          = 11;
   localparam int unsigned FD_MSB          = 10;
   // Serial register addresses
   localparam logic [4:0]  SA_OUTPUTS      = 5'h00;
   localparam logic [4:0]  SA_PWM          = 5'h01;
   localparam logic [4:0]  SA_DUTY0        = 5'h02;
   localparam logic [4:0]  SA_DUTY3        = 5'h05;
   localparam logic [4:0]  SA_SENSE        = 5'h06;
   localparam logic [4:0]  SA_FAULT_CLR    = 5'h07;
   // Duty codes for fully off and fully on
   localparam logic [7:0]  DUTY_OFF        = 8'h00;
   localparam logic [7:0]  DUTY_FULL       = 8'hff;
   // Bus register byte addresses and response codes
   localparam logic [7:0]  RA_CTRL         = 8'h00;
   localparam logic [7:0]  RA_STATUS       = 8'h04;
   localparam logic [7:0]  RA_LAST_FRAME   = 8'h08;
   localparam logic [7:0]  RA_SPI_CFG      = 8'h0c;
   localparam logic [7:0]  RA_DUTY         = 8'h10;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef struct packed {
      logic            cs_s1, cs_s2, cs_s3;
      logic            ck_s1, ck_s2, ck_s3;
      logic            si_s1, si_s2;
      logic            rst_s1, rst_s2, rst_s3;
      logic            wk_s1, wk_s2;
      logic [3:0]      in_s1, in_s2;
      logic            in0_s3;
      logic            vdd_s1, vdd_s2;
      logic [3:0]      flt_s1, flt_s2;
      logic [15:0]     rx, tx, last_frame;
      logic [4:0]      bitcnt;
      logic [3:0]      on_bits, dir_dis;
      logic            pwm_en, clock_sel;
      logic [3:0][7:0] duty;
      logic [2:0]      sense_sel;
      logic            sense_off;
      logic [3:0]      fault_lat;
      logic            clk_fail;
      logic [31:0]     wd_cnt;
      logic            wd_run, wd_to;
      logic [15:0]     pwm_div;
      logic [7:0]      pwm_cnt;
      logic [31:0]     edge_gap;
      logic            vdd_en, wd_en;
      logic            aw_rdy, w_rdy, aw_full, w_full;
      logic [7:0]      awaddr;
      logic [31:0]     wdata;
      logic            wstrb0;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            ar_rdy, rvalid;
      logic [31:0]     rdata;
      logic [1:0]      rresp;
      logic            so, so_oe_n, ff_oe_n, fail_safe;
      logic [3:0]      hs;
   } state_s;
endpackage : lamp_pkg
`default_nettype wire

// [hw/lamp_switch_serial_control_port.sv]
// Serial control port and pin-level control of a four-channel lamp switch.
// Assumes pins arrive asynchronously to aclk; software uses AXI4-Lite.
//
// Overview of operation
// - Serial input bits are sampled on serial clock falling edges.
// - Serial output advances one status bit per serial clock rising edge.
// - A frame holds exactly sixteen bits, most significant first.
// - A five-bit address field in the frame picks the target register.
// - Frame select rise moves received bits into the addressed register.
// - Frame select fall loads current status into the shift register.
// - Serial output is driven only while frame select is low.
// - Clock and data activity is ignored while frame select is high.
// - Reset input low clears configuration and faults; sleep also needs wake and direct inputs low.
// - Reset input rising edge starts the watchdog timer.
// - Any direct input, the wake input or reset input wakes the device.
// - Each direct input drives its power output while PWM is off, unless disabled by the serial port.
// - External PWM clock option takes its reference from the first input.
// - Fault flag is pulled low on any fault, released otherwise.
// - Loss of the serial port supply moves the device to fail-safe.
// - Clock fail detector runs only with PWM enabled and external clock.
// - PWM duty supports fully on and fully off settings.
// - Serial port selects current or temperature sense, or tri-states it.
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`default_nettype none
module lamp_switch_serial_control_port #(
   parameter int unsigned WD_CYC       = lamp_pkg::WD_CYC_DEF,
   parameter int unsigned CLK_FAIL_CYC = lamp_pkg::CLK_FAIL_CYC_DEF
) (
   input  wire logic        aclk,            // System clock
   input  wire logic        aresetn,         // Synchronous reset, low
   input  wire logic        awvalid,         // Write address valid
   output logic             awready,         // Write address ready
   input  wire logic [7:0]  awaddr,          // Write byte address
   input  wire logic        wvalid,          // Write data valid
   output logic             wready,          // Write data ready
   input  wire logic [31:0] wdata,           // Write data
   input  wire logic [3:0]  wstrb,           // Write byte enables
   output logic             bvalid,          // Write response valid
   input  wire logic        bready,          // Write response ready
   output logic [1:0]       bresp,           // Write response code
   input  wire logic        arvalid,         // Read address valid
   output logic             arready,         // Read address ready
   input  wire logic [7:0]  araddr,          // Read byte address
   output logic             rvalid,          // Read data valid
   input  wire logic        rready,          // Read data ready
   output logic [31:0]      rdata,           // Read data
   output logic [1:0]       rresp,           // Read response code
   input  wire logic        frame_select_n,  // Frame select, low in frame
   input  wire logic        sclk,            // Serial clock
   input  wire logic        si,              // Serial data in
   output logic             so_o,            // Serial data out
   output logic             so_oe_n,         // Serial out enable, low
   input  wire logic        reset_n_input,   // Device reset pin, low
   input  wire logic        wake,            // Wake pin
   input  wire logic [3:0]  direct_inputs,   // Direct output controls
   input  wire logic        vdd_ok,          // Logic supply present
   input  wire logic [3:0]  fault_detect,    // Per-channel fault sensors
   output logic [3:0]       power_outputs,   // High-side switch gates
   output logic             fault_flag_n_o,  // Fault flag level, always 0
   output logic             fault_flag_n_oe_n, // Fault flag pull, low
   output logic [2:0]       sense_sel,       // Sense source, 4 = temp
   output logic             sense_off,       // Sense output tri-state
   output logic             fail_safe        // Fail-safe mode active
);
   import lamp_pkg::*;

   localparam logic [31:0] WD_LAST = 32'(WD_CYC - 1);
   localparam logic [31:0] CF_LAST = 32'(CLK_FAIL_CYC - 1);

   state_s q;
   state_s n;

   logic        cs_fall, cs_rise, ck_rise, ck_fall, rst_rise;
   logic        awake, fail, ext_clk, pwm_clock_input, in0_rise, pwm_tick;
   logic        frame_ok;
   logic [4:0]  faddr;
   logic [10:0] fdata;
   logic [3:0]  pwm_on, hson;
   logic [15:0] status;
   logic        aw_hs, w_hs, ar_hs, do_write;

   function automatic logic duty_on(input logic [7:0] d,
                                    input logic [7:0] c);
      if (d == DUTY_FULL) begin
         duty_on = 1'b1;
      end else if (d == DUTY_OFF) begin
         duty_on = 1'b0;
      end else begin
         duty_on = (c < d);
      end
   endfunction : duty_on

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == RA_CTRL) || (a == RA_STATUS) ||
                   (a == RA_LAST_FRAME) || (a == RA_SPI_CFG) ||
                   (a == RA_DUTY);
   endfunction : addr_known

   assign cs_fall  = q.cs_s3 & ~q.cs_s2;
   assign cs_rise  = ~q.cs_s3 & q.cs_s2;
   assign ck_rise  = ~q.ck_s3 & q.ck_s2 & ~q.cs_s2;
   assign ck_fall  = q.ck_s3 & ~q.ck_s2 & ~q.cs_s2;
   assign rst_rise = q.rst_s2 & ~q.rst_s3;
   assign awake    = q.rst_s2 | q.wk_s2 | (|q.in_s2);
   assign fail     = (q.vdd_en & ~q.vdd_s2) | (q.wd_en & q.wd_to);
   assign ext_clk  = q.pwm_en & ~q.clock_sel;
   assign pwm_clock_input = q.in_s2[0];
   assign in0_rise = pwm_clock_input & ~q.in0_s3;
   assign pwm_tick = ext_clk ? in0_rise : (q.pwm_div == PWM_DIV_LAST);
   assign frame_ok = cs_rise & (q.bitcnt == FRAME_BITS);
   assign faddr    = q.rx[FA_MSB:FA_LSB];
   assign fdata    = q.rx[FD_MSB:0];

   for (genvar i = 0; i < 4; i++) begin : g_pwm
      assign pwm_on[i] = duty_on(q.duty[i], q.pwm_cnt);
   end

   // Direct path when PWM is off, gated by duty when it is on
   assign hson = (((q.in_s2 & ~q.dir_dis) | q.on_bits) &
                  {4{~q.pwm_en}}) |
                 (q.on_bits & pwm_on & {4{q.pwm_en}});
   assign status = {q.fail_safe, |q.fault_lat, q.clk_fail, awake,
                    q.fault_lat, q.hs, q.in_s2};

   assign aw_hs    = awvalid & q.aw_rdy;
   assign w_hs     = wvalid & q.w_rdy;
   assign ar_hs    = arvalid & q.ar_rdy;
   assign do_write = q.aw_full & q.w_full & ~q.bvalid;

   always_comb begin
      n = q;
      // Two-stage synchronisers for every pin
      n.cs_s1  = frame_select_n;
      n.cs_s2  = q.cs_s1;
      n.cs_s3  = q.cs_s2;
      n.ck_s1  = sclk;
      n.ck_s2  = q.ck_s1;
      n.ck_s3  = q.ck_s2;
      n.si_s1  = si;
      n.si_s2  = q.si_s1;
      n.rst_s1 = reset_n_input;
      n.rst_s2 = q.rst_s1;
      n.rst_s3 = q.rst_s2;
      n.wk_s1  = wake;
      n.wk_s2  = q.wk_s1;
      n.in_s1  = direct_inputs;
      n.in_s2  = q.in_s1;
      n.in0_s3 = q.in_s2[0];
      n.vdd_s1 = vdd_ok;
      n.vdd_s2 = q.vdd_s1;
      n.flt_s1 = fault_detect;
      n.flt_s2 = q.flt_s1;

      // Serial shifter
      n.so_oe_n = q.cs_s2;
      if (cs_fall) begin
         n.tx     = status;
         n.so     = status[15];
         n.bitcnt = '0;
      end else if (ck_rise) begin
         n.tx = {q.tx[14:0], 1'b0};
         n.so = q.tx[14];
      end
      if (ck_fall) begin
         n.rx = {q.rx[14:0], q.si_s2};
         if (q.bitcnt != BITCNT_SAT) begin
            n.bitcnt = q.bitcnt + 5'h01;
         end
      end

      // Frame commit into the addressed register
      if (frame_ok) begin
         n.last_frame = q.rx;
         case (faddr)
            SA_OUTPUTS: begin
               n.on_bits = fdata[3:0];
               n.dir_dis = fdata[7:4];
            end
            SA_PWM: begin
               n.pwm_en    = fdata[0];
               n.clock_sel = fdata[1];
            end
            SA_SENSE: begin
               n.sense_sel = fdata[2:0];
               n.sense_off = fdata[3];
            end
            SA_FAULT_CLR: begin
               n.fault_lat = q.fault_lat & ~fdata[3:0];
               n.clk_fail  = q.clk_fail & ~fdata[4];
            end
            default: begin
               if (faddr >= SA_DUTY0 && faddr <= SA_DUTY3) begin
                  n.duty[2'(faddr - SA_DUTY0)] = fdata[7:0];
               end
            end
         endcase
      end

      // PWM timebase and external clock supervision
      if (ext_clk || q.pwm_div == PWM_DIV_LAST) begin
         n.pwm_div = '0;
      end else begin
         n.pwm_div = q.pwm_div + 16'h0001;
      end
      if (pwm_tick) begin
         n.pwm_cnt = q.pwm_cnt + 8'h01;
      end
      if (!ext_clk || in0_rise) begin
         n.edge_gap = '0;
      end else if (q.edge_gap != CF_LAST) begin
         n.edge_gap = q.edge_gap + 32'h0000_0001;
      end

      // Fault capture, a new fault wins over a clear
      n.fault_lat = n.fault_lat | q.flt_s2;
      if (ext_clk && q.edge_gap == CF_LAST) begin
         n.clk_fail = 1'b1;
      end

      // Watchdog, restarted by every good frame
      if (rst_rise) begin
         n.wd_run = 1'b1;
      end
      if (!q.wd_run || frame_ok) begin
         n.wd_cnt = '0;
         n.wd_to  = 1'b0;
      end else if (q.wd_cnt == WD_LAST) begin
         n.wd_to = 1'b1;
      end else begin
         n.wd_cnt = q.wd_cnt + 32'h0000_0001;
      end

      // Device reset pin clears configuration and faults
      if (!q.rst_s2) begin
         n.wd_run    = 1'b0;
         n.on_bits   = '0;
         n.dir_dis   = '0;
         n.pwm_en    = 1'b0;
         n.clock_sel = 1'b0;
         n.duty      = '0;
         n.sense_sel = '0;
         n.sense_off = 1'b0;
         n.fault_lat = '0;
         n.clk_fail  = 1'b0;
      end

      // Power stage and flags
      if (!awake) begin
         n.hs = '0;
      end else if (fail) begin
         n.hs = q.in_s2;
      end else begin
         n.hs = hson & ~q.fault_lat;
      end
      n.fail_safe = awake & fail;
      n.ff_oe_n   = ~((|q.fault_lat) | q.clk_fail);

      // Bus slave
      if (aw_hs) begin
         n.aw_full = 1'b1;
         n.awaddr  = awaddr;
      end
      if (w_hs) begin
         n.w_full = 1'b1;
         n.wdata  = wdata;
         n.wstrb0 = wstrb[0];
      end
      if (do_write) begin
         n.aw_full = 1'b0;
         n.w_full  = 1'b0;
         n.bvalid  = 1'b1;
         n.bresp   = addr_known(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
         if (q.awaddr == RA_CTRL && q.wstrb0) begin
            n.vdd_en = q.wdata[0];
            n.wd_en  = q.wdata[1];
         end
      end
      if (q.bvalid && bready) begin
         n.bvalid = 1'b0;
      end
      if (ar_hs) begin
         n.rvalid = 1'b1;
         n.rresp  = addr_known(araddr) ? RESP_OKAY : RESP_SLVERR;
         case (araddr)
            RA_CTRL:       n.rdata = {30'h0000_0000, q.wd_en, q.vdd_en};
            RA_STATUS:     n.rdata = {16'h0000, status};
            RA_LAST_FRAME: n.rdata = {16'h0000, q.last_frame};
            RA_SPI_CFG:    n.rdata = {16'h0000, 2'h0, q.sense_off,
                                      q.sense_sel, q.clock_sel, q.pwm_en,
                                      q.dir_dis, q.on_bits};
            RA_DUTY:       n.rdata = q.duty;
            default:       n.rdata = 32'h0000_0000;
         endcase
      end
      if (q.rvalid && rready) begin
         n.rvalid = 1'b0;
      end
      n.aw_rdy = ~n.aw_full & ~n.bvalid;
      n.w_rdy  = ~n.w_full & ~n.bvalid;
      n.ar_rdy = ~n.rvalid;

      if (!aresetn) begin
         n         = '0;
         n.cs_s1   = 1'b1;
         n.cs_s2   = 1'b1;
         n.cs_s3   = 1'b1;
         n.so_oe_n = 1'b1;
         n.ff_oe_n = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      q <= n;
   end

   assign awready           = q.aw_rdy;
   assign wready            = q.w_rdy;
   assign bvalid            = q.bvalid;
   assign bresp             = q.bresp;
   assign arready           = q.ar_rdy;
   assign rvalid            = q.rvalid;
   assign rdata             = q.rdata;
   assign rresp             = q.rresp;
   assign so_o              = q.so;
   assign so_oe_n           = q.so_oe_n;
   assign power_outputs     = q.hs;
   assign fault_flag_n_o    = 1'b0;
   assign fault_flag_n_oe_n = q.ff_oe_n;
   assign sense_sel         = q.sense_sel;
   assign sense_off         = q.sense_off;
   assign fail_safe         = q.fail_safe;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_rx_sample: assert property (ck_fall
      |=> q.rx[0] == $past(q.si_s2))
      else $error("serial bit not sampled on falling clock");
   a_tx_shift: assert property (ck_rise && !cs_fall
      |=> q.so == $past(q.tx[14]))
      else $error("serial output did not advance");
   a_short_frame: assert property (cs_rise && q.bitcnt != FRAME_BITS
      && q.rst_s2 |=> $stable(q.on_bits) && $stable(q.last_frame))
      else $error("frame of wrong length was committed");
   a_frame_commit: assert property (frame_ok && faddr == SA_OUTPUTS
      && q.rst_s2 |=> q.on_bits == $past(q.rx[3:0]))
      else $error("frame not committed to addressed register");
   a_status_load: assert property (cs_fall |=> q.so == $past(status[15])
      ##1 !q.so_oe_n)
      else $error("status not loaded at frame start");
   a_so_hiz: assert property (q.cs_s2 |=> q.so_oe_n)
      else $error("serial output driven outside frame");
   a_idle_ignore: assert property (q.cs_s2 |=> $stable(q.rx))
      else $error("shifter moved while deselected");
   a_reset_clear: assert property (!q.rst_s2 |=> q.on_bits == 4'h0
      && q.fault_lat == 4'h0 && !q.pwm_en)
      else $error("reset pin did not clear configuration");
   a_wd_start: assert property (rst_rise |=> q.wd_run
      ##1 (q.wd_cnt == 32'h0000_0000 || q.wd_cnt == 32'h0000_0001))
      else $error("watchdog did not start on reset release");
   a_sleep_off: assert property (!awake |=> q.hs == 4'h0)
      else $error("outputs on while asleep");
   a_direct_on: assert property (awake && !fail && !q.pwm_en && q.in_s2[1]
      && !q.dir_dis[1] && !q.fault_lat[1] |=> q.hs[1])
      else $error("direct input did not switch output");
   a_ext_tick: assert property (ext_clk && in0_rise
      |=> q.pwm_cnt == $past(q.pwm_cnt) + 8'h01)
      else $error("external PWM clock edge not counted");
   a_fault_flag: assert property (q.fault_lat != 4'h0 |=> !q.ff_oe_n)
      else $error("fault flag not pulled low");
   a_fail_safe: assert property (awake && q.vdd_en && !q.vdd_s2
      |=> q.fail_safe && q.hs == $past(q.in_s2))
      else $error("no fail-safe on supply loss");
   a_cf_gate: assert property (!ext_clk |=> q.edge_gap == 32'h0000_0000
      ##1 !$rose(q.clk_fail))
      else $error("clock failure detector ran while disabled");
   a_duty_full: assert property (awake && !fail && q.pwm_en && q.on_bits[0]
      && q.duty[0] == DUTY_FULL && !q.fault_lat[0] |=> q.hs[0])
      else $error("full duty did not hold output on");
   a_sense_cfg: assert property (frame_ok && faddr == SA_SENSE && q.rst_s2
      |=> sense_sel == $past(q.rx[2:0])
      && sense_off == $past(q.rx[3]))
      else $error("sense configuration not applied");

   c_frame: cover property (frame_ok);
   c_fail_safe: cover property ($rose(q.fail_safe));
   c_fault: cover property ($fell(q.ff_oe_n));
   c_bus_rd: cover property (q.rvalid && rready);
endmodule : lamp_switch_serial_control_port
`default_nettype wire

// [tb/lamp_host_model.sv]
// Host serial master model that clocks frames into the lamp switch.
// Assumes the bench calls xfer; link clock period 125 ns, idle low.
`default_nettype none
module lamp_host_model (
   output logic      frame_select_n, // Frame select, low in frame
   output logic      sclk,           // Serial clock
   output logic      si,             // Serial data in
   input  wire logic so_o,           // Serial out level
   input  wire logic so_oe_n         // Serial out enable, low
);
   timeunit 1ns;
   timeprecision 100ps;
   // Undriven line shows the inverse, never a stale level
   wire logic line = so_oe_n ? ~so_o : so_o;
   initial begin
      frame_select_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   task automatic xfer(input logic [15:0] w, input int n,
                       output logic [15:0] r);
      r = 16'h0000;
      frame_select_n = 1'b0;
      #500;
      for (int i = 0; i < n; i++) begin
         r = {r[14:0], line};
         sclk = 1'b1;
         si = w[15 - i];
         #62.5 sclk = 1'b0;
         #62.5;
      end
      #100 frame_select_n = 1'b1;
      si = 1'b0;
      #1000;
   endtask : xfer
endmodule : lamp_host_model
`default_nettype wire

// [tb/lamp_switch_serial_control_port_tb_top.sv]
// Self-checking bench for the lamp switch serial port and its bus.
// Assumes lamp_pkg and the host model lamp_host_model.
`default_nettype none
module lamp_switch_serial_control_port_tb_top;
   import lamp_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [15:0] f;
      logic [3:0]  pw;
      logic [3:0]  sn;
   } row_s;
   logic        aclk = 1'b0, aresetn = 1'b0, awready, wready, bvalid;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, arready, rvalid, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, rd;
   logic [3:0]  wstrb = 4'hf, direct_inputs = 4'h0, fault_detect = 4'h0;
   logic [3:0]  power_outputs, prev = 4'h0;
   logic [1:0]  bresp, rresp;
   logic        frame_select_n, sclk, si, so_o, so_oe_n, sense_off;
   logic        reset_n_input = 1'b1, wake = 1'b0, vdd_ok = 1'b1;
   logic        fault_flag_n_oe_n, fail_safe;
   logic [2:0]  sense_sel;
   logic [15:0] rx;
   int          error_cnt = 0, cmp_count = 0;
   row_s rows [7] = '{'{16'h0005, 4'h5, 4'h0}, '{16'h3004, 4'h5, 4'h4},
      '{16'h3008, 4'h5, 4'h8}, '{16'h0803, 4'h0, 4'h8},
      '{16'h10ff, 4'h1, 4'h8}, '{16'h1000, 4'h0, 4'h8},
      '{16'h0800, 4'h5, 4'h8}};

   lamp_switch_serial_control_port #(.WD_CYC(200), .CLK_FAIL_CYC(100))
      dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
             .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
             .wready(wready), .wdata(wdata), .wstrb(wstrb),
             .bvalid(bvalid), .bready(bready), .bresp(bresp),
             .arvalid(arvalid), .arready(arready), .araddr(araddr),
             .rvalid(rvalid), .rready(rready), .rdata(rdata),
             .rresp(rresp), .frame_select_n(frame_select_n),
             .sclk(sclk), .si(si), .so_o(so_o), .so_oe_n(so_oe_n),
             .reset_n_input(reset_n_input), .wake(wake),
             .direct_inputs(direct_inputs), .vdd_ok(vdd_ok),
             .fault_detect(fault_detect), .power_outputs(power_outputs),
             .fault_flag_n_o(), .fault_flag_n_oe_n(fault_flag_n_oe_n),
             .sense_sel(sense_sel), .sense_off(sense_off),
             .fail_safe(fail_safe));
   lamp_host_model host_u (.frame_select_n(frame_select_n),
                           .sclk(sclk), .si(si), .so_o(so_o),
                           .so_oe_n(so_oe_n));

   always #4 aclk = ~aclk;

   task automatic chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(bresp === er, "bresp");
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
                         input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata;
      chk(rresp === er, "rresp");
   endtask : rd_reg
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : wait_cyc
   task automatic end_sim;
      $display("errors %0d, checks %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim

   initial begin
      #400_000;
      error_cnt++;
      end_sim();
   end
   initial begin
      wait_cyc(8);
      aresetn <= 1'b1;
      wait_cyc(625);
      foreach (rows[i]) begin
         host_u.xfer(rows[i].f, 16, rx);
         chk(rx === {4'h1, 4'h0, prev, 4'h0}, "status");
         chk(power_outputs === rows[i].pw, "outputs");
         chk({sense_off, sense_sel} === rows[i].sn, "sense");
         chk(so_oe_n === 1'b1, "so idle");
         rd_reg(RA_LAST_FRAME, rd, RESP_OKAY);
         chk(rd[15:0] === rows[i].f, "frame");
         prev = rows[i].pw;
      end
      host_u.xfer(16'h0003, 15, rx);
      rd_reg(RA_LAST_FRAME, rd, RESP_OKAY);
      chk(rd[15:0] === 16'h0800, "short frame");
      direct_inputs <= 4'h8;
      wait_cyc(10);
      chk(power_outputs === 4'hd, "direct");
      wr_reg(RA_CTRL, 32'h0000_0001, RESP_OKAY);
      vdd_ok <= 1'b0;
      wait_cyc(10);
      chk(fail_safe === 1'b1 && power_outputs === 4'h8, "vdd");
      vdd_ok <= 1'b1;
      fault_detect <= 4'h2;
      wait_cyc(10);
      chk(fault_flag_n_oe_n === 1'b0, "fault");
      fault_detect <= 4'h0;
      host_u.xfer(16'h381f, 16, rx);
      chk(fault_flag_n_oe_n === 1'b1, "fault clear");
      host_u.xfer(16'h0801, 16, rx);
      wait_cyc(150);
      chk(fault_flag_n_oe_n === 1'b0, "clock fail");
      wr_reg(8'h14, 32'h0000_0000, RESP_SLVERR);
      rd_reg(8'h14, rd, RESP_SLVERR);
      wr_reg(RA_CTRL, 32'h0000_0002, RESP_OKAY);
      reset_n_input <= 1'b0;
      direct_inputs <= 4'h0;
      wait_cyc(1250);
      rd_reg(RA_SPI_CFG, rd, RESP_OKAY);
      chk(rd === 32'h0000_0000 && power_outputs === 4'h0, "sleep");
      chk(fail_safe === 1'b0, "wd idle");
      reset_n_input <= 1'b1;
      wait_cyc(300);
      chk(fail_safe === 1'b1, "watchdog");
      end_sim();
   end
endmodule : lamp_switch_serial_control_port_tb_top
`default_nettype wire
